// ===== hw/sbrg_top.sv
// Rate generator of the serial port with APB registers and receive majority sampling
`timescale 1ns/100ps
`default_nettype none
module sbrg_top
   import sbrg_pkg::*;
(
   input  wire logic        pclk,        // Device clock, 100 MHz
   input  wire logic        presetn,     // Asynchronous reset, low
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_clk_in,  // Slave-mode clock from the line
   input  wire logic        rx_in,       // Receive line
   output logic             bit_tick,    // One pulse per bit period (timer, or external clock edge in slave)
   output logic             sample_tick, // Receive sampling strobe
   output logic             rx_level,    // Majority-voted receive level
   output logic             sync_clk_out // Synchronous master clock
);
   // Register storage
   logic [7:0]  txsc_ff, rxsc_ff, baudc_ff, divh_ff, divl_ff;
   logic [7:0]  nxt_txsc, nxt_rxsc, nxt_baudc, nxt_divh, nxt_divl;
   // Bus answer registers
   logic [31:0] prdata_ff, nxt_prdata;
   logic        pready_ff, nxt_pready;
   logic        pslverr_ff, nxt_pslverr;
   // Timer state
   logic [5:0]  pre_ff, nxt_pre;           // Prescale counter
   logic [15:0] cnt_ff, nxt_cnt;           // Divisor counter
   logic        tick_ff, nxt_tick;         // Bit period pulse
   logic        samp_ff, nxt_samp;         // Sample strobe
   logic        sclk_ff, nxt_sclk;         // Master clock level
   logic        ext_q_ff;                  // Last external clock level
   // Derived controls
   logic        sync_mode, master, wide, hspeed, port_en;
   logic [15:0] n_val;
   logic [5:0]  pre_top;
   logic        acc, wr, div_wr;

   // Bus access phase: answered in the access cycle itself, no waits
   assign acc = psel & penable;
   assign wr  = acc & pwrite;

   // Address decoding for the error answer of reads and writes
   function automatic logic addr_hit(input logic [7:0] a);
      addr_hit = (a == SBRG_ADDR_TXSC) || (a == SBRG_ADDR_RXSC) || (a == SBRG_ADDR_BAUDC)
              || (a == SBRG_ADDR_DIVH) || (a == SBRG_ADDR_DIVL);
   endfunction

   // Controls pulled from the registers
   assign sync_mode = txsc_ff[SBRG_BIT_SYNC];
   assign master    = txsc_ff[SBRG_BIT_CLOCK_SOURCE_SELECT];
   assign wide      = baudc_ff[SBRG_BIT_WIDE];
   assign hspeed    = txsc_ff[SBRG_BIT_HIGH_SPEED_SELECT] & ~sync_mode;
   assign port_en   = rxsc_ff[SBRG_BIT_SPEN];
   // Upper byte dropped while narrow
   assign n_val     = wide ? {divh_ff, divl_ff} : {8'h00, divl_ff};
   assign div_wr    = wr && ((paddr == SBRG_ADDR_DIVH) || (paddr == SBRG_ADDR_DIVL));

   // Prescale choice; the timer itself counts n+1 prescaled steps
   always_comb
   begin
      if (sync_mode || (wide && hspeed))
         pre_top = SBRG_PRE_4;
      else if (wide || hspeed)
         pre_top = SBRG_PRE_16;
      else
         pre_top = SBRG_PRE_64;
   end

   // Register write path
   always_comb
   begin
      nxt_txsc  = txsc_ff;
      nxt_rxsc  = rxsc_ff;
      nxt_baudc = baudc_ff;
      nxt_divh  = divh_ff;
      nxt_divl  = divl_ff;
      if (wr)
      begin
         if (paddr == SBRG_ADDR_TXSC)
            nxt_txsc = (pwdata[7:0] & SBRG_WMASK_TXSC) | (txsc_ff & ~SBRG_WMASK_TXSC);
         else if (paddr == SBRG_ADDR_RXSC)
            nxt_rxsc = (pwdata[7:0] & SBRG_WMASK_RXSC) | (rxsc_ff & ~SBRG_WMASK_RXSC);
         else if (paddr == SBRG_ADDR_BAUDC)
            nxt_baudc = (pwdata[7:0] & SBRG_WMASK_BAUDC) | (baudc_ff & ~SBRG_WMASK_BAUDC);
         else if (paddr == SBRG_ADDR_DIVH)
            nxt_divh = pwdata[7:0];
         else if (paddr == SBRG_ADDR_DIVL)
            nxt_divl = pwdata[7:0];
      end
      // Idle status tracks the voted line level
      nxt_baudc[SBRG_BIT_RCIDL] = rx_level;
   end

   // Read path and answer; unmapped addresses give an error
   always_comb
   begin
      nxt_prdata  = 32'h0000_0000;
      nxt_pready  = 1'b0;
      nxt_pslverr = 1'b0;
      if (psel && !penable)
      begin
         nxt_pready  = 1'b1;
         nxt_pslverr = ~addr_hit(paddr);
         if (!pwrite)
         begin
            if (paddr == SBRG_ADDR_TXSC)
               nxt_prdata = {24'h000000, txsc_ff};
            else if (paddr == SBRG_ADDR_RXSC)
               nxt_prdata = {24'h000000, rxsc_ff};
            else if (paddr == SBRG_ADDR_BAUDC)
               nxt_prdata = {24'h000000, baudc_ff};
            else if (paddr == SBRG_ADDR_DIVH)
               nxt_prdata = {24'h000000, divh_ff};
            else if (paddr == SBRG_ADDR_DIVL)
               nxt_prdata = {24'h000000, divl_ff};
         end
      end
   end

   // Free-running timer on the device clock; its rate follows that clock
   always_comb
   begin
      nxt_pre  = pre_ff;
      nxt_cnt  = cnt_ff;
      nxt_tick = 1'b0;
      nxt_samp = 1'b0;
      nxt_sclk = sclk_ff;
      if (div_wr || !port_en)
      begin
         // Clearing here avoids waiting out a stale long count
         nxt_pre = 6'h00;
         nxt_cnt = 16'h0000;
      end
      else if (pre_ff >= pre_top)
      begin
         nxt_pre = 6'h00;
         if (cnt_ff >= n_val)
         begin
            nxt_cnt  = 16'h0000;
            // One generator for every mode; slave ignores it
            nxt_tick = ~(sync_mode & ~master);
            if (sync_mode && master)
               nxt_sclk = ~sclk_ff;
         end
         else
            nxt_cnt = cnt_ff + 16'h0001;
      end
      else
         nxt_pre = pre_ff + 6'h01;
      // Sample strobe: three back-to-back strobes in the last step of each asynchronous bit.
      // Keeping them in the last step gives three samples even when n is zero.
      if (!sync_mode && port_en && !div_wr && cnt_ff >= n_val
          && pre_ff >= pre_top - 6'h02)
         nxt_samp = 1'b1;
      // Slave mode: bit events come from the external clock edge
      if (sync_mode && !master && port_en && ext_clk_in && !ext_q_ff)
      begin
         nxt_tick = 1'b1;
         nxt_samp = 1'b1;
      end
   end

   // Registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         txsc_ff    <= SBRG_RST_TXSC;
         rxsc_ff    <= SBRG_RST_RXSC;
         baudc_ff   <= SBRG_RST_BAUDC;
         divh_ff    <= SBRG_RST_DIV;
         divl_ff    <= SBRG_RST_DIV;
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         pre_ff     <= 6'h00;
         cnt_ff     <= 16'h0000;
         tick_ff    <= 1'b0;
         samp_ff    <= 1'b0;
         sclk_ff    <= 1'b0;
         ext_q_ff   <= 1'b0;
      end
      else
      begin
         txsc_ff    <= nxt_txsc;
         rxsc_ff    <= nxt_rxsc;
         baudc_ff   <= nxt_baudc;
         divh_ff    <= nxt_divh;
         divl_ff    <= nxt_divl;
         prdata_ff  <= nxt_prdata;
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         pre_ff     <= nxt_pre;
         cnt_ff     <= nxt_cnt;
         tick_ff    <= nxt_tick;
         samp_ff    <= nxt_samp;
         sclk_ff    <= nxt_sclk;
         ext_q_ff   <= ext_clk_in;
      end
   end

   // Majority detector on the receive line
   sbrg_majority u_maj (
      .pclk       (pclk),
      .presetn    (presetn),
      .sample_stb (samp_ff),
      .rx_in      (rx_in),
      .rx_level   (rx_level)
   );

   assign prdata       = prdata_ff;
   assign pready       = pready_ff;
   assign pslverr      = pslverr_ff;
   assign bit_tick     = tick_ff;
   assign sample_tick  = samp_ff;
   assign sync_clk_out = sclk_ff;

   chk_narrow_ignore : assert property (@(posedge pclk) disable iff (!presetn)
      !wide |-> n_val == {8'h00, divl_ff}) else $error("upper byte used while narrow");
   chk_div_clear : assert property (@(posedge pclk) disable iff (!presetn)
      div_wr |=> cnt_ff == 16'h0000 && pre_ff == 6'h00) else $error("timer not cleared");
   chk_ratio_fast : assert property (@(posedge pclk) disable iff (!presetn)
      sync_mode |-> pre_top == SBRG_PRE_4) else $error("sync ratio wrong");
   chk_ratio_slow : assert property (@(posedge pclk) disable iff (!presetn)
      (!sync_mode && !wide && !txsc_ff[SBRG_BIT_HIGH_SPEED_SELECT]) |-> pre_top == SBRG_PRE_64)
      else $error("low speed ratio wrong");
   chk_ratio_mid : assert property (@(posedge pclk) disable iff (!presetn)
      (!sync_mode && (wide ^ txsc_ff[SBRG_BIT_HIGH_SPEED_SELECT])) |-> pre_top == SBRG_PRE_16)
      else $error("mid ratio wrong");
   chk_ratio_wide_hs : assert property (@(posedge pclk) disable iff (!presetn)
      (wide && txsc_ff[SBRG_BIT_HIGH_SPEED_SELECT]) |-> pre_top == SBRG_PRE_4)
      else $error("wide high speed ratio wrong");
   chk_tick_period : assert property (@(posedge pclk) disable iff (!presetn)
      (port_en && !sync_mode && !wide && !txsc_ff[SBRG_BIT_HIGH_SPEED_SELECT] && divl_ff == 8'h00
       && !div_wr) ##1 tick_ff |-> ##64 tick_ff) else $error("bit period wrong");
   chk_slave_quiet : assert property (@(posedge pclk) disable iff (!presetn)
      (sync_mode && !master && !(ext_clk_in && !ext_q_ff)) |=> !tick_ff)
      else $error("tick from timer in slave mode");
   chk_bus_answer : assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready) else $error("no answer");
   cover_async_tick : cover property (@(posedge pclk) disable iff (!presetn)
      !sync_mode && tick_ff);
   cover_sync_tick : cover property (@(posedge pclk) disable iff (!presetn)
      sync_mode && master && tick_ff);
   cover_slave_tick : cover property (@(posedge pclk) disable iff (!presetn)
      sync_mode && !master && tick_ff);
   cover_div_write : cover property (@(posedge pclk) disable iff (!presetn) div_wr);
endmodule
`default_nettype wire

// ===== pkg/sbrg_pkg.sv
// Package with register map, field positions, reset values and divide ratios of the rate generator
//
// How it works
// - Eight-bit divisor at reset, wide when selected
// - Free-running timer, period from divisor pair
// - High-speed bit only matters in asynchronous mode
// - Ratios apply to master; slave uses external clock
// - Async, narrow, low speed: divide 64(n+1)
// - Async, wide, low speed: divide 16(n+1)
// - Synchronous master: divide 4(n+1)
// - Divisor write clears the timer at once
// - Timing follows the current device clock
// - Three receive samples, majority vote decides
// - Divisor split over high and low bytes
// - One generator serves async and sync modes
// - Narrow divisor ignores the upper byte
// - Clock-source bit: 1 master, 0 slave
`default_nettype none
package sbrg_pkg;
   // Byte addresses of the registers on APB
   localparam logic [7:0] SBRG_ADDR_TXSC   = 8'h00;
   localparam logic [7:0] SBRG_ADDR_RXSC   = 8'h04;
   localparam logic [7:0] SBRG_ADDR_BAUDC  = 8'h08;
   localparam logic [7:0] SBRG_ADDR_DIVH   = 8'h0C;
   localparam logic [7:0] SBRG_ADDR_DIVL   = 8'h10;
   // Field positions
   localparam int SBRG_BIT_CLOCK_SOURCE_SELECT   = 7;  // Clock source select
   localparam int SBRG_BIT_SYNC   = 4;  // Synchronous mode
   localparam int SBRG_BIT_HIGH_SPEED_SELECT   = 2;  // High speed select
   localparam int SBRG_BIT_WIDE   = 3;  // Wide divisor select
   localparam int SBRG_BIT_SPEN   = 7;  // Port enable
   localparam int SBRG_BIT_RCIDL  = 6;  // Receive idle status
   // Reset values
   localparam logic [7:0] SBRG_RST_TXSC  = 8'h02;
   localparam logic [7:0] SBRG_RST_RXSC  = 8'h00;
   localparam logic [7:0] SBRG_RST_BAUDC = 8'h40;
   localparam logic [7:0] SBRG_RST_DIV   = 8'h00;
   // Writable bits (read-only and unimplemented bits are masked)
   localparam logic [7:0] SBRG_WMASK_TXSC  = 8'hFD;
   localparam logic [7:0] SBRG_WMASK_RXSC  = 8'hF8;
   localparam logic [7:0] SBRG_WMASK_BAUDC = 8'h9B;
   // Prescale terminal counts: one less than the device clocks per timer step
   localparam logic [5:0] SBRG_PRE_64 = 6'h3F;
   localparam logic [5:0] SBRG_PRE_16 = 6'h0F;
   localparam logic [5:0] SBRG_PRE_4  = 6'h03;
   // Number of receive samples per bit
   localparam int SBRG_NSAMP = 3;
endpackage
`default_nettype wire

// ===== hw/sbrg_majority.sv
// Three-sample majority detector for the receive line
`timescale 1ns/100ps
`default_nettype none
module sbrg_majority
   import sbrg_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic sample_stb,   // Take one sample of the line
   input  wire logic rx_in,        // Receive line, synchronous
   output logic      rx_level      // Majority level
);
   logic [SBRG_NSAMP-1:0] samp_ff;       // Last three samples
   logic [SBRG_NSAMP-1:0] nxt_samp;
   logic                  lvl_ff;        // Voted level
   logic                  nxt_lvl;

   // Shift in a sample on each strobe and vote two of three
   always_comb
   begin
      nxt_samp = samp_ff;
      nxt_lvl  = lvl_ff;
      if (sample_stb)
      begin
         nxt_samp = {samp_ff[1:0], rx_in};
         nxt_lvl  = (nxt_samp[0] & nxt_samp[1]) | (nxt_samp[0] & nxt_samp[2])
                  | (nxt_samp[1] & nxt_samp[2]);
      end
   end

   // Idle line is high, so samples start high
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         samp_ff <= 3'h7;
         lvl_ff  <= 1'b1;
      end
      else
      begin
         samp_ff <= nxt_samp;
         lvl_ff  <= nxt_lvl;
      end
   end

   assign rx_level = lvl_ff;

   chk_vote_majority : assert property (@(posedge pclk) disable iff (!presetn)
      sample_stb ##1 1'b1 |-> rx_level == ((samp_ff[0] + samp_ff[1] + samp_ff[2]) >= 2'd2))
      else $error("majority vote wrong");
   cover_sample_low : cover property (@(posedge pclk) disable iff (!presetn) $fell(rx_level));
endmodule
`default_nettype wire

// ===== verification/sbrg_top_tb.sv
// Self-checking testbench of the rate generator: APB tasks, period and sample counts
`timescale 1ns/100ps
`default_nettype none
module sbrg_top_tb
   import sbrg_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite;   // Clock, reset and APB control
   logic [7:0]  paddr;                                  // APB byte address
   logic [31:0] pwdata, prdata, rd;                     // Write data, read data, last read
   logic        pready, pslverr, err;                   // Answer and last error flag
   logic        ext_clk_in, rx_in;                      // Line inputs
   logic        bit_tick, sample_tick, rx_level, sync_clk_out;
   int          n_mismatch, n_compared, n_tick, n_samp; // Tallies
   int          per, t0, k;                             // Scratch
   // Rate table: control values and expected bit period in device clocks, divisor 0x0102 (n = 2 when narrow)
   localparam logic [7:0]  TX_T [7] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h90, 8'h94, 8'h94};
   localparam logic [7:0]  BC_T [7] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h00, 8'h08};
   localparam logic [31:0] PER_T [7] = '{192, 48, 4144, 1036, 12, 12, 1036};

   sbrg_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_clk_in(ext_clk_in), .rx_in(rx_in), .bit_tick(bit_tick),
      .sample_tick(sample_tick), .rx_level(rx_level), .sync_clk_out(sync_clk_out));

   // 100 MHz device clock
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Pulses are counted on the falling edge, where registered outputs have settled
   always @(negedge pclk)
   begin
      n_tick = n_tick + int'(bit_tick === 1'b1);
      n_samp = n_samp + int'(sample_tick === 1'b1);
   end

   task automatic report_and_stop();
      if (n_mismatch == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // One APB transfer; the request is held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 16);
      if (pready !== 1'b1)
         n_mismatch++;
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h000000, d});
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk(rd, {24'h000000, exp});
   endtask

   // Falling edges until the next bit tick, bounded so a silent generator cannot hang
   task automatic wait_tick(output int c);
      c = 0;
      do
      begin
         @(negedge pclk);
         c++;
      end
      while (bit_tick !== 1'b1 && c < 20000);
   endtask

   // The first interval may be partial after a change, so the second one is kept
   task automatic measure(output int p);
      wait_tick(p);
      wait_tick(p);
   endtask

   // Watchdog: the whole run needs about 40k cycles, so 70k is a safe limit
   initial
   begin
      #700000;
      n_mismatch++;
      report_and_stop();
   end

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      ext_clk_in = 1'b0;
      rx_in = 1'b1;
      n_mismatch = 0;
      n_compared = 0;
      n_tick = 0;
      n_samp = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, then an unmapped place that must refuse and store nothing
      rdchk(SBRG_ADDR_TXSC, SBRG_RST_TXSC);
      rdchk(SBRG_ADDR_RXSC, SBRG_RST_RXSC);
      rdchk(SBRG_ADDR_BAUDC, SBRG_RST_BAUDC);
      rdchk(SBRG_ADDR_DIVH, SBRG_RST_DIV);
      rdchk(SBRG_ADDR_DIVL, SBRG_RST_DIV);
      apb(1'b1, 8'h14, 32'h000000FF);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 8'h14, 32'h00000000);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      wr(SBRG_ADDR_DIVH, 8'hA5);
      rdchk(SBRG_ADDR_DIVH, 8'hA5);
      wr(SBRG_ADDR_BAUDC, 8'h08);
      rdchk(SBRG_ADDR_BAUDC, 8'h48);
      // Every divide mode; narrow rows must ignore the upper byte
      wr(SBRG_ADDR_RXSC, 8'h80);
      wr(SBRG_ADDR_DIVH, 8'h01);
      wr(SBRG_ADDR_DIVL, 8'h02);
      for (k = 0; k < 7; k++)
      begin
         wr(SBRG_ADDR_TXSC, TX_T[k]);
         wr(SBRG_ADDR_BAUDC, BC_T[k]);
         measure(per);
         chk(32'(per), PER_T[k]);
         // Master clock toggles on each tick in synchronous master mode only
         t0 = int'(sync_clk_out);
         wait_tick(per);
         chk({31'h0, sync_clk_out}, {31'h0, 1'(t0) ^ (TX_T[k][4] & TX_T[k][7])});
      end
      // Synchronous slave: one tick per rising edge of the external clock
      wr(SBRG_ADDR_TXSC, 8'h10);
      repeat (4) @(posedge pclk);
      t0 = n_tick;
      repeat (5)
      begin
         repeat (10) @(posedge pclk);
         ext_clk_in <= 1'b1;
         repeat (10) @(posedge pclk);
         ext_clk_in <= 1'b0;
      end
      repeat (10) @(posedge pclk);
      chk(32'(n_tick - t0), 32'd5);
      // Rewriting the divisor mid-count restarts the full 64 x 256 period
      wr(SBRG_ADDR_TXSC, 8'h00);
      wr(SBRG_ADDR_BAUDC, 8'h00);
      wr(SBRG_ADDR_DIVL, 8'hFF);
      repeat (1000) @(posedge pclk);
      wr(SBRG_ADDR_DIVL, 8'hFF);
      wait_tick(per);
      chk(32'(per >= 16376 && per <= 16392), 32'h1);
      // Three samples per bit at 16 clocks a bit, then the voted level both ways
      wr(SBRG_ADDR_TXSC, 8'h04);
      wr(SBRG_ADDR_DIVL, 8'h00);
      repeat (40) @(posedge pclk);
      t0 = n_samp;
      repeat (160) @(posedge pclk);
      chk(32'(n_samp - t0), 32'd30);
      rx_in <= 1'b0;
      repeat (48) @(posedge pclk);
      chk({31'h0, rx_level}, 32'h0);
      rdchk(SBRG_ADDR_BAUDC, 8'h00);
      rx_in <= 1'b1;
      repeat (48) @(posedge pclk);
      chk({31'h0, rx_level}, 32'h1);
      rdchk(SBRG_ADDR_BAUDC, 8'h40);
      // Low speed with n of zero: one bit every 64 device clocks
      wr(SBRG_ADDR_TXSC, 8'h00);
      measure(per);
      chk(32'(per), 32'h40);
      report_and_stop();
   end
endmodule
`default_nettype wire
